// >>> src/acs_target.sv
// Purpose: Sensor end of the two-wire bus, target only
// Assumes: Register contents live outside; rd_data follows reg_addr
// Notes: Written bytes leave through a two-entry buffer
`timescale 1ns/1ps
module acs_target import acs_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  acs_bus_if.dev bus,
  output logic [7:0] reg_addr,
  output logic rd_strobe,
  input wire logic [7:0] rd_data,
  output logic rx_valid,
  output logic [7:0] rx_addr,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic alert_en,
  input wire logic orient_event,
  input wire logic alert_clear,
  input wire logic sensor_fault,
  output logic alert_o,
  output logic alert_oe
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RECV = 3'b001,
    D_RACK = 3'b010,
    D_SEND = 3'b011,
    D_SACK = 3'b100,
    D_IGNORE = 3'b101
  } acs_dstate_e;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    acs_dstate_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic is_addr;
    logic ptr_next;
    logic rw;
    logic ack;
    logic drive_low;
    logic [7:0] addr;
    logic rd_strobe;
    logic alert;
  } acs_dev_s;

  localparam acs_dev_s D_RST = '{
    scl_sync: 3'h7,
    sda_sync: 3'h7,
    st: D_IDLE,
    cnt: 4'h0,
    sh: 8'h00,
    is_addr: 1'b0,
    ptr_next: 1'b0,
    rw: 1'b0,
    ack: 1'b0,
    drive_low: 1'b0,
    addr: ADDR_RESET,
    rd_strobe: 1'b0,
    alert: 1'b0
  };

  acs_dev_s r;
  acs_dev_s next_r;
  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic push;
  logic buf_in_ready;
  logic [15:0] buf_out;

  // ----------------------------------------
  // Line events
  // ----------------------------------------
  assign scl_s = r.scl_sync[1];
  assign scl_p = r.scl_sync[2];
  assign sda_s = r.sda_sync[1];
  assign sda_p = r.sda_sync[2];
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_seen = scl_s && scl_p && !sda_s && sda_p;
  assign stop_seen = scl_s && scl_p && sda_s && !sda_p;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.sda_o_dev = 1'b0;
  assign bus.sda_oe_dev = r.drive_low;
  assign reg_addr = r.addr;
  assign rd_strobe = r.rd_strobe;
  assign rx_addr = buf_out[15:8];
  assign rx_data = buf_out[7:0];
  assign alert_o = r.alert;
  assign alert_oe = !sensor_fault;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    push = 1'b0;
    next_r.rd_strobe = 1'b0;
    next_r.scl_sync = {r.scl_sync[1:0], bus.scl};
    next_r.sda_sync = {r.sda_sync[1:0], bus.sda};
    if (alert_en && orient_event) begin
      next_r.alert = 1'b1;
    end else if (alert_clear) begin
      next_r.alert = 1'b0;
    end
    if (start_seen) begin
      next_r.st = D_RECV;
      next_r.cnt = 4'h0;
      next_r.is_addr = 1'b1;
      next_r.drive_low = 1'b0;
    end else if (stop_seen) begin
      next_r.st = D_IDLE;
      next_r.cnt = 4'h0;
      next_r.drive_low = 1'b0;
    end else begin
      unique case (r.st)
        D_IDLE, D_IGNORE: begin
          next_r.drive_low = 1'b0;
        end
        D_RECV: begin
          if (scl_rise) begin
            next_r.sh = {r.sh[6:0], sda_s};
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'(BYTE_BITS)) begin
            next_r.st = D_RACK;
            next_r.ack = 1'b0;
            if (r.is_addr) begin
              if (r.sh[7:1] == DEV_ADDR) begin
                next_r.ack = 1'b1;
                next_r.rw = r.sh[0];
                next_r.ptr_next = !r.sh[0];
              end
            end else if (r.ptr_next) begin
              next_r.ack = 1'b1;
              next_r.addr = r.sh;
              next_r.ptr_next = 1'b0;
            end else if (buf_in_ready) begin
              next_r.ack = 1'b1;
              push = 1'b1;
              next_r.addr = r.addr + 8'h01;
            end
            next_r.drive_low = next_r.ack;
          end
        end
        D_RACK: begin
          if (scl_fall) begin
            next_r.cnt = 4'h0;
            next_r.is_addr = 1'b0;
            if (!r.ack) begin
              next_r.st = D_IGNORE;
              next_r.drive_low = 1'b0;
            end else if (r.is_addr && r.rw) begin
              next_r.st = D_SEND;
              next_r.sh = rd_data;
              next_r.rd_strobe = 1'b1;
              next_r.drive_low = !rd_data[7];
            end else begin
              next_r.st = D_RECV;
              next_r.drive_low = 1'b0;
            end
          end
        end
        D_SEND: begin
          if (scl_fall) begin
            next_r.cnt = r.cnt + 4'h1;
            next_r.sh = {r.sh[6:0], 1'b0};
            if (r.cnt == 4'(BYTE_BITS - 1)) begin
              next_r.st = D_SACK;
              next_r.ack = 1'b0;
              next_r.drive_low = 1'b0;
              next_r.addr = r.addr + 8'h01;
            end else begin
              next_r.drive_low = !r.sh[6];
            end
          end
        end
        D_SACK: begin
          if (scl_rise) begin
            next_r.ack = !sda_s;
          end else if (scl_fall) begin
            next_r.cnt = 4'h0;
            if (r.ack) begin
              next_r.st = D_SEND;
              next_r.sh = rd_data;
              next_r.rd_strobe = 1'b1;
              next_r.drive_low = !rd_data[7];
            end else begin
              next_r.st = D_IGNORE;
              next_r.drive_low = 1'b0;
            end
          end
        end
        default: begin
          next_r.st = D_IDLE;
          next_r.drive_low = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= D_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Written-byte buffer
  // ----------------------------------------
  acs_fifo2 #(
    .W(16),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(push),
    .in_data({r.addr, r.sh}),
    .in_ready(buf_in_ready),
    .out_valid(rx_valid),
    .out_data(buf_out),
    .out_ready(rx_ready)
  );

endmodule : acs_target

// >>> src/acs_pkg.sv
// Purpose: Shared constants and types for the two-wire sensor port
// Assumes: 10 MHz system clock on both ends
// Notes on behaviour
// - answer only target address 0010101b
// - pure target, clock line input only
// - data pin open drain, never driven high
// - master starts transfers, makes serial clock
// - data changes only while clock low
// - detect start and stop with clock high
// - both lines released while bus idle
// - bytes of eight bits, MSB first
// - master gives nine clocks per byte
// - sender releases, receiver acks on ninth
// - master may stop after missing ack
// - master ends read by not acking
// - target releases data after unacked read
// - master waits 30 ms after power-up
// - master never holds lines low 10 ms
// - alert low, high on event, off on fault
// - alert on orientation change is optional
// - first byte is address plus direction
// - first written byte loads address counter
// - counter increments after every data byte; a written byte nacked while the buffer is full leaves it unchanged
// - read: write pointer, repeated start, read
package acs_pkg;

  // ----------------------------------------
  // Addresses and widths
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h15;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int WAIT_W = 20;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int SCL_KHZ = 100;
  localparam int HALF_CYC = CLK_KHZ / (2 * SCL_KHZ);
  localparam int POWERUP_MS = 30;
  localparam int POWERUP_CYC = POWERUP_MS * CLK_KHZ;
  localparam int LOW_MAX_MS = 10;
  localparam int LOW_MAX_CYC = LOW_MAX_MS * CLK_KHZ;
  localparam int HOLD_CYC = LOW_MAX_CYC / 2;

  // ----------------------------------------
  // Master commands
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ = 2'b10,
    CMD_STOP = 2'b11
  } acs_cmd_e;

endpackage : acs_pkg

// >>> src/acs_bus_if.sv
// Purpose: Two-wire bus between master end and sensor end
// Assumes: Open-drain lines with pull-ups
// Notes: Line level is the wired AND of all pull-downs
`timescale 1ns/1ps
interface acs_bus_if;
  logic scl_o_mst;
  logic scl_oe_mst;
  logic sda_o_mst;
  logic sda_oe_mst;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  assign scl = !(scl_oe_mst && !scl_o_mst);
  assign sda = !((sda_oe_mst && !sda_o_mst) || (sda_oe_dev && !sda_o_dev));

  modport dev (input scl, input sda, output sda_o_dev, output sda_oe_dev);
  modport mst (input scl, input sda, output scl_o_mst, output scl_oe_mst,
               output sda_o_mst, output sda_oe_mst);
endinterface : acs_bus_if

// >>> src/acs_fifo2.sv
// Purpose: Small buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full drops in_ready, the target then nacks the byte
`timescale 1ns/1ps
module acs_fifo2 import acs_pkg::*; #(
  parameter int W = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } acs_fifo_s;

  acs_fifo_s r;
  acs_fifo_s next_r;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule : acs_fifo2

// >>> src/acs_master.sv
// Purpose: Bus master end, byte commands to two-wire cycles
// Assumes: Serial clock made here by dividing clk
// Notes: Long holds of the clock low end in an automatic stop
`timescale 1ns/1ps
module acs_master import acs_pkg::*; #(
  parameter int HALF = HALF_CYC,
  parameter int POWERUP_WAIT = POWERUP_CYC,
  parameter int HOLD_LIMIT = HOLD_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  acs_bus_if.mst bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire acs_cmd_e cmd_kind,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    M_PWR = 3'b000,
    M_IDLE = 3'b001,
    M_HOLD = 3'b010,
    M_START = 3'b011,
    M_BIT = 3'b100,
    M_STOP = 3'b101
  } acs_mstate_e;

  typedef struct packed {
    acs_mstate_e st;
    logic [1:0] step;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [7:0] ph;
    logic [WAIT_W-1:0] tmr;
    logic scl_low;
    logic sda_low;
    logic [1:0] sda_sync;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } acs_mst_s;

  acs_mst_s r;
  acs_mst_s next_r;
  logic tick;

  assign tick = (r.ph == 8'(HALF - 1));
  assign cmd_ready = (r.st == M_IDLE) || (r.st == M_HOLD);
  assign bus.scl_o_mst = 1'b0;
  assign bus.scl_oe_mst = r.scl_low;
  assign bus.sda_o_mst = 1'b0;
  assign bus.sda_oe_mst = r.sda_low;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_nack = r.rsp_nack;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.sda_sync = {r.sda_sync[0], bus.sda};
    next_r.ph = tick ? 8'h00 : r.ph + 8'h01;
    unique case (r.st)
      M_PWR: begin
        next_r.tmr = r.tmr + 1'b1;
        if (r.tmr == WAIT_W'(POWERUP_WAIT - 1)) begin
          next_r.st = M_IDLE;
        end
      end
      M_IDLE, M_HOLD: begin
        next_r.ph = 8'h00;
        next_r.step = 2'h0;
        next_r.bitn = 4'h0;
        next_r.tmr = r.tmr + 1'b1;
        if (cmd_valid && cmd_kind == CMD_START) begin
          next_r.st = M_START;
        end else if (cmd_valid && r.st == M_HOLD) begin
          next_r.st = (cmd_kind == CMD_STOP) ? M_STOP : M_BIT;
          next_r.sh = (cmd_kind == CMD_READ) ? {8'hff, cmd_last} : {cmd_data, 1'b1};
        end else if (r.st == M_HOLD && r.tmr == WAIT_W'(HOLD_LIMIT - 1)) begin
          next_r.st = M_STOP;
        end
      end
      M_START: begin
        if (r.step == 2'h0 && r.ph == 8'h00) begin
          next_r.sda_low = 1'b0;
        end
        if (tick) begin
          next_r.step = r.step + 2'h1;
          if (r.step == 2'h0) begin
            next_r.scl_low = 1'b0;
          end else if (r.step == 2'h1) begin
            next_r.sda_low = 1'b1;
          end else begin
            next_r.scl_low = 1'b1;
            next_r.st = M_HOLD;
            next_r.tmr = '0;
          end
        end
      end
      M_BIT: begin
        if (r.step == 2'h0 && r.ph == 8'h00) begin
          next_r.sda_low = !r.sh[8];
        end
        if (tick && r.step == 2'h0) begin
          next_r.scl_low = 1'b0;
          next_r.step = 2'h1;
        end else if (tick) begin
          next_r.sh = {r.sh[7:0], r.sda_sync[1]};
          next_r.scl_low = 1'b1;
          next_r.step = 2'h0;
          next_r.bitn = r.bitn + 4'h1;
          if (r.bitn == 4'(BYTE_BITS)) begin
            next_r.st = M_HOLD;
            next_r.tmr = '0;
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = r.sh[7:0];
            next_r.rsp_nack = r.sda_sync[1];
          end
        end
      end
      M_STOP: begin
        if (r.step == 2'h0 && r.ph == 8'h00) begin
          next_r.sda_low = 1'b1;
        end
        if (tick && r.step == 2'h0) begin
          next_r.scl_low = 1'b0;
          next_r.step = 2'h1;
        end else if (tick) begin
          next_r.sda_low = 1'b0;
          next_r.st = M_IDLE;
        end
      end
      default: begin
        next_r.st = M_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{st: M_PWR, sda_sync: 2'h3, default: '0};
    end else if (ce) begin
      r <= next_r;
    end
  end

endmodule : acs_master

// >>> testbench/acs_bus_assertions.sv
// Purpose: Line checks for the two-wire sensor port
// Assumes: Shortened timing, HALF of 8 clk
// Notes: Sees only the bus signals
`timescale 1ns/1ps
module acs_bus_assertions #(
  parameter int LOW_MAX = 4000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o_mst,
  input wire logic scl_oe_mst,
  input wire logic sda_o_mst,
  input wire logic sda_oe_mst,
  input wire logic sda_o_dev,
  input wire logic sda_oe_dev
);
  // ----------------------------------------
  // Clock low time
  // ----------------------------------------
  logic [15:0] low_cnt;
  always_ff @(posedge clk) begin
    if (reset || scl) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_dev_open_drain: assert property (sda_oe_dev |-> !sda_o_dev)
    else $error("target drives data high");
  a_mst_open_drain: assert property ((!scl_oe_mst || !scl_o_mst)
    && (!sda_oe_mst || !sda_o_mst))
    else $error("master drives a line high");
  a_idle_after_reset: assert property ($fell(reset) |-> scl && sda)
    else $error("lines not idle after reset");
  a_dev_change_low: assert property (!$stable(sda_oe_dev) |-> !scl && !$past(scl))
    else $error("target data changed with clock high");
  a_start_then_low: assert property ($rose(sda_oe_mst) && scl |-> ##[4:12] !scl)
    else $error("no clock low after start");
  a_stop_dev_free: assert property ($fell(sda_oe_mst) && scl |-> !sda_oe_dev [*8])
    else $error("target drives after stop");
  a_ack_whole_pulse: assert property (sda_oe_dev && $rose(scl) |-> sda_oe_dev [*8])
    else $error("target bit not held over clock pulse");
  a_low_time_max: assert property (int'(low_cnt) <= LOW_MAX)
    else $error("clock held low too long");
endmodule : acs_bus_assertions

// >>> testbench/accel_i2c_slave_port_tb.sv
// Purpose: Self-checking bench, master end facing target end
// Assumes: HALF 8, power-up wait 100, hold limit 2000
// Notes: Register contents modelled as address xor a5
`timescale 1ns/1ps
module accel_i2c_slave_port_tb import acs_pkg::*;;
  logic clk, reset, ce, cmd_valid, cmd_last, rx_ready, rd_strobe, rx_valid;
  logic cmd_ready, rsp_valid, rsp_nack, alert_en, orient_event, alert_clear;
  logic sensor_fault, alert_o, alert_oe;
  logic [7:0] cmd_data, rsp_data, reg_addr, rd_data, rx_addr, rx_data, p;
  logic [7:0] d0, d1, d2;
  logic [6:0] bad[4];
  acs_cmd_e cmd_kind;
  int err_count, num_checks, seed;
  int rises = 0;
  int r0 = 0;
  int strobes = 0;
  logic scl_q = 1'b1;
  acs_bus_if bus ();
  acs_master #(.HALF(8), .POWERUP_WAIT(100), .HOLD_LIMIT(2000)) acs_master_i (.clk(clk),
    .reset(reset), .ce(ce), .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  acs_target acs_target_i (.clk(clk), .reset(reset), .ce(ce), .bus(bus), .reg_addr(reg_addr),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rx_valid(rx_valid), .rx_addr(rx_addr),
    .rx_data(rx_data), .rx_ready(rx_ready), .alert_en(alert_en), .orient_event(orient_event),
    .alert_clear(alert_clear), .sensor_fault(sensor_fault), .alert_o(alert_o),
    .alert_oe(alert_oe));
  acs_bus_assertions #(.LOW_MAX(4000)) acs_bus_assertions_i (.clk(clk), .reset(reset),
    .scl(bus.scl), .sda(bus.sda), .scl_o_mst(bus.scl_o_mst), .scl_oe_mst(bus.scl_oe_mst),
    .sda_o_mst(bus.sda_o_mst), .sda_oe_mst(bus.sda_oe_mst), .sda_o_dev(bus.sda_o_dev),
    .sda_oe_dev(bus.sda_oe_dev));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] reg_val(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction : reg_val
  assign rd_data = reg_val(reg_addr);
  always #50 clk = ~clk;
  // Serial clock pulses and register load strobes
  always @(posedge clk) begin
    scl_q <= bus.scl;
    if (bus.scl === 1'b1 && scl_q === 1'b0) begin
      rises <= rises + 1;
    end
    if (rd_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input acs_cmd_e k, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge clk);
    cmd_kind <= k;
    cmd_data <= d;
    cmd_last <= l;
    cmd_valid <= 1'b1;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    chk("cmd ready", 8'h01, {7'h00, cmd_ready});
    @(posedge clk);
    cmd_valid <= 1'b0;
    r0 = rises;
    n = 0;
    if (k == CMD_WRITE || k == CMD_READ) begin
      @(negedge clk);
      while (rsp_valid !== 1'b1 && n < 1000) begin
        n++;
        @(negedge clk);
      end
      chk("rsp wait", 8'h01, {7'h00, rsp_valid});
    end
  endtask : cmd
  task automatic wr(input logic [7:0] d, input logic nack);
    cmd(CMD_WRITE, d, 1'b0);
    chk("write ack", {7'h00, nack}, {7'h00, rsp_nack});
    chk("write echo", d, rsp_data);
    chk("scl pulses", 8'd9, 8'(rises - r0));
  endtask : wr
  task automatic rd(input logic [7:0] exp, input logic last);
    cmd(CMD_READ, 8'h00, last);
    chk("read data", exp, rsp_data);
    chk("read ack", {7'h00, last}, {7'h00, rsp_nack});
  endtask : rd
  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    chk("rx wait", 8'h01, {7'h00, rx_valid});
    chk("rx addr", a, rx_addr);
    chk("rx data", d, rx_data);
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(negedge clk);
  endtask : pop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge clk);
    $display("[ERR] watchdog expected done seen timeout");
    err_count++;
    end_sim();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    {cmd_valid, cmd_last, rx_ready, alert_en, orient_event, alert_clear, sensor_fault} = '0;
    cmd_kind = CMD_START;
    cmd_data = 8'h00;
    err_count = 0;
    num_checks = 0;
    seed = $urandom(32'hcef2);
    bad = '{7'h14, 7'h35, 7'h55, 7'h16};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (90) @(posedge clk);
    @(negedge clk);
    chk("power-up busy", 8'h00, {7'h00, cmd_ready});
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("power-up done", 8'h01, {7'h00, cmd_ready});
    for (int t = 0; t < 2; t++) begin
      p = t ? 8'hff : 8'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      cmd(CMD_START, 8'h00, 1'b0);
      wr({DEV_ADDR, 1'b0}, 1'b0);
      wr(p, 1'b0);
      wr(d0, 1'b0);
      wr(d1, 1'b0);
      chk("counter", p + 8'd2, reg_addr);
      wr(d2, 1'b1);
      cmd(CMD_STOP, 8'h00, 1'b0);
      pop(p, d0);
      pop(p + 8'd1, d1);
      chk("rx empty", 8'h00, {7'h00, rx_valid});
      $display("test write %0d done", t);
    end
    cmd(CMD_START, 8'h00, 1'b0);
    repeat (2100) @(posedge clk);
    chk("idle lines", 8'h03, {6'h00, bus.scl, bus.sda});
    $display("test hold done");
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_START, 8'h00, 1'b0);
      wr({bad[i], i[0]}, 1'b1);
      wr(8'($urandom), 1'b1);
      cmd(CMD_STOP, 8'h00, 1'b0);
      chk("rx none", 8'h00, {7'h00, rx_valid});
    end
    $display("test wrong address done");
    p = 8'($urandom);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_ADDR, 1'b0}, 1'b0);
    wr(p, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_ADDR, 1'b1}, 1'b0);
    rd(reg_val(p), 1'b0);
    rd(reg_val(p + 8'd1), 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("read counter", p + 8'd2, reg_addr);
    chk("read strobes", 8'd2, 8'(strobes));
    $display("test read done");
    @(posedge clk);
    alert_en <= 1'b1;
    orient_event <= 1'b1;
    @(posedge clk);
    orient_event <= 1'b0;
    @(negedge clk);
    chk("alert set", 8'h01, {7'h00, alert_o});
    @(posedge clk);
    alert_clear <= 1'b1;
    alert_en <= 1'b0;
    @(posedge clk);
    alert_clear <= 1'b0;
    orient_event <= 1'b1;
    @(posedge clk);
    orient_event <= 1'b0;
    @(negedge clk);
    chk("alert off", 8'h00, {7'h00, alert_o});
    chk("alert drive", 8'h01, {7'h00, alert_oe});
    @(posedge clk);
    sensor_fault <= 1'b1;
    @(negedge clk);
    chk("alert fault", 8'h00, {7'h00, alert_oe});
    @(posedge clk);
    alert_en <= 1'b1;
    orient_event <= 1'b1;
    alert_clear <= 1'b1;
    @(posedge clk);
    orient_event <= 1'b0;
    alert_clear <= 1'b0;
    @(negedge clk);
    chk("alert set wins", 8'h01, {7'h00, alert_o});
    $display("test alert done");
    end_sim();
  end
endmodule : accel_i2c_slave_port_tb
